// ### verilog/spi_busy_pkg.sv

package spi_busy_pkg;

  // ==========================================================
  // clock and link timing
  localparam int CLOCK_HZ = 40_000_000;
  localparam int CLOCK_NS = 25;
  localparam int LINK_BPS = 1_000_000;
  localparam int MIN_BPS = 200_000;
  localparam int HALF_BIT = CLOCK_HZ / (2 * LINK_BPS);
  localparam logic [5:0] HALF_LAST = 6'(HALF_BIT - 1);
  localparam int SLOT_US = 1000;
  localparam int SLOT_CYCLES = SLOT_US * (CLOCK_HZ / 1_000_000);
  localparam int TIMEOUT_NS = 16_000;
  // longest wait, so rounded down
  localparam int TIMEOUT_CYCLES = TIMEOUT_NS / CLOCK_NS;
  localparam logic [9:0] TIMEOUT_LAST = 10'(TIMEOUT_CYCLES - 1);

  // ==========================================================
  // character and command format
  localparam int CHAR_BITS = 8;
  localparam logic [5:0] MAX_CHARS = 6'h3F;
  localparam logic [5:0] DEFAULT_CHARS = 6'h08;
  localparam logic [7:0] CMD_STATUS = 8'h00;
  localparam logic [1:0] OP_STATUS = 2'h0;
  localparam logic [1:0] OP_MASTER_READ = 2'h1;
  localparam logic [1:0] OP_MASTER_WRITE = 2'h2;
  localparam logic [1:0] OP_EXCHANGE = 2'h3;
  localparam logic [1:0] REPLY_CAN_TX = 2'h1;
  localparam logic [1:0] REPLY_CAN_RX = 2'h0;
  localparam logic [5:0] STATUS_REPLY_CHARS = 6'h01;
  localparam logic [7:0] IDLE_FILL = 8'h00;

  // ==========================================================
  // state encodings
  typedef enum logic [2:0] {
    S_IDLE, S_PREP, S_CMD, S_EXEC, S_DATA, S_DONE
  } dev_state_t;

  typedef enum logic [2:0] {
    M_IDLE, M_SEL, M_BYTE, M_WAIT_HI, M_WAIT_LO, M_END
  } mst_state_t;

  // ==========================================================
  // operation decoding shared by both ends
  function automatic logic slave_sends(input logic [1:0] op);
    slave_sends = (op == OP_MASTER_READ) || (op == OP_EXCHANGE);
  endfunction : slave_sends

  function automatic logic slave_takes(input logic [1:0] op);
    slave_takes = (op == OP_MASTER_WRITE) || (op == OP_EXCHANGE);
  endfunction : slave_takes

endpackage : spi_busy_pkg

// ### verilog/spi_busy_link_if.sv
`timescale 1ns/1ps
interface spi_busy_link_if;
  // master driven lines
  logic sck;
  logic cs_n;
  logic mosi;
  // slave driven lines, two signals each
  logic miso_o;
  logic miso_oe;
  logic busy_o;
  logic busy_oe;
  // resolved wire levels; both lines carry a pull-up
  logic miso;
  logic busy_n;

  // a released line floats up to high
  assign miso = miso_oe ? miso_o : 1'b1;
  assign busy_n = busy_oe ? busy_o : 1'b1;

  modport device (
    input sck,
    input cs_n,
    input mosi,
    output miso_o,
    output miso_oe,
    output busy_o,
    output busy_oe
  );

  modport master (
    output sck,
    output cs_n,
    output mosi,
    input miso,
    input busy_n
  );
endinterface : spi_busy_link_if

// ### verilog/spi_busy_device.sv
`timescale 1ns/1ps
module spi_busy_device
  import spi_busy_pkg::*;
(
  // system clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // link to the master
  spi_busy_link_if.device LINK,
  // transmit data from the local user
  input wire logic [5:0] TX_COUNT,
  input wire logic [7:0] TX_DATA,
  output logic TX_NEXT,
  // receive data towards the local user
  input wire logic [5:0] RX_ROOM,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  // slot status
  output logic SELECTED,
  output logic [7:0] LAST_CMD,
  output logic ABORTED
);

  // ==========================================================
  // link domain, clocked by the master's serial clock
  // the link side has no timer of its own, so any bit rate
  // from the nominal one down to the slowest works

  typedef struct packed {
    logic [6:0] shift;
    logic [7:0] rx_byte;
    logic rx_toggle;
  } link_t;

  typedef struct packed {
    logic miso;
    logic miso_en;
  } out_t;

  typedef struct packed {
    dev_state_t state;
    logic cs_meta;
    logic cs_sync;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic [1:0] op;
    logic [5:0] total;
    logic [5:0] done_cnt;
    logic [7:0] tx_word;
    logic busy_low;
    logic tx_next;
    logic [7:0] rx_data;
    logic rx_valid;
    logic selected;
    logic [7:0] last_cmd;
    logic aborted;
  } sys_t;

  localparam sys_t SYS_RESET = '{
    state: S_IDLE,
    cs_meta: 1'b1,
    cs_sync: 1'b1,
    default: '0
  };

  logic [2:0] bit_cnt;
  logic link_clear_n;
  link_t link;
  link_t next_link;
  out_t pin;
  out_t next_pin;
  sys_t r;
  sys_t next_r;

  // deselect clears the bit position at once; sck may be
  // frozen, so no clocked clear could be relied on
  assign link_clear_n = RESET_N & ~LINK.cs_n;

  // bit position inside the current character
  always_ff @(posedge LINK.sck or negedge link_clear_n) begin
    if (!link_clear_n) begin
      bit_cnt <= 3'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // sample input on the rising edge, MSB arrives first
  always_comb begin
    next_link = link;
    next_link.shift = {link.shift[5:0], LINK.mosi};
    if (bit_cnt == 3'h7) begin
      next_link.rx_byte = {link.shift, LINK.mosi};
      next_link.rx_toggle = ~link.rx_toggle;
    end
  end

  // toggle is not cleared by deselect: a clear there could
  // reach the system side before the deselect and fake a byte
  always_ff @(posedge LINK.sck or negedge RESET_N) begin
    if (!RESET_N) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // type 1: output changes on the falling edge, idle high
  // tx_word only changes before busy shows ready or, between data
  // characters, in the half bit before the next fall, so reading it here is a safe crossing
  always_comb begin
    next_pin.miso = r.tx_word[~bit_cnt];
    next_pin.miso_en = 1'b1;
  end

  // deselect releases the data line at once
  always_ff @(negedge LINK.sck or negedge link_clear_n) begin
    if (!link_clear_n) begin
      pin <= '0;
    end else begin
      pin <= next_pin;
    end
  end

  assign LINK.miso_o = pin.miso;
  assign LINK.miso_oe = pin.miso_en;

  // ==========================================================
  // system domain: handshake and slot sequencing

  logic byte_evt;
  logic [5:0] count_after;

  assign byte_evt = r.tog_sync != r.tog_seen;
  assign count_after = r.done_cnt + 6'h01;

  always_comb begin
    next_r = r;
    // two flops before anything reads the pins
    next_r.cs_meta = LINK.cs_n;
    next_r.cs_sync = r.cs_meta;
    next_r.tog_meta = link.rx_toggle;
    next_r.tog_sync = r.tog_meta;
    next_r.tog_seen = r.tog_sync;
    next_r.tx_next = 1'b0;
    next_r.rx_valid = 1'b0;
    next_r.aborted = 1'b0;
    next_r.selected = ~r.cs_sync;
    case (r.state)
      S_IDLE: begin
        next_r.busy_low = 1'b0;
        if (!r.cs_sync) begin
          next_r.tx_word = IDLE_FILL;
          next_r.state = S_PREP;
        end
      end
      S_PREP: begin
        // filler is stable before ready is shown
        next_r.busy_low = 1'b1;
        next_r.state = S_CMD;
      end
      S_CMD: begin
        if (byte_evt) begin
          next_r.busy_low = 1'b0;
          next_r.last_cmd = link.rx_byte;
          next_r.op = link.rx_byte[7:6];
          next_r.total = link.rx_byte[5:0];
          next_r.state = S_EXEC;
        end
      end
      S_EXEC: begin
        next_r.done_cnt = 6'h00;
        if (r.last_cmd == CMD_STATUS) begin
          // report what can be sent, else what fits
          if (TX_COUNT != 6'h00) begin
            next_r.tx_word = {REPLY_CAN_TX, TX_COUNT};
          end else begin
            next_r.tx_word = {REPLY_CAN_RX, RX_ROOM};
          end
          next_r.op = OP_STATUS;
          next_r.total = STATUS_REPLY_CHARS;
          next_r.busy_low = 1'b1;
          next_r.state = S_DATA;
        end else if (r.op == OP_STATUS || r.total == 6'h00) begin
          // undefined code or empty slot: stay busy
          next_r.state = S_DONE;
        end else begin
          if (slave_sends(r.op)) begin
            next_r.tx_word = TX_DATA;
            next_r.tx_next = 1'b1;
          end else begin
            next_r.tx_word = IDLE_FILL;
          end
          next_r.busy_low = 1'b1;
          next_r.state = S_DATA;
        end
      end
      S_DATA: begin
        if (byte_evt) begin
          if (slave_takes(r.op)) begin
            next_r.rx_data = link.rx_byte;
            next_r.rx_valid = 1'b1;
          end
          next_r.done_cnt = count_after;
          if (count_after == r.total) begin
            next_r.busy_low = 1'b0;
            next_r.state = S_DONE;
          end else if (slave_sends(r.op)) begin
            // master gives half a bit before the next fall
            next_r.tx_word = TX_DATA;
            next_r.tx_next = 1'b1;
          end
        end
      end
      S_DONE: begin
        next_r.busy_low = 1'b0;
      end
      default: begin
        next_r.state = S_IDLE;
      end
    endcase
    // deselect wins over everything the slot was doing
    if (r.cs_sync && r.state != S_IDLE) begin
      next_r.busy_low = 1'b0;
      next_r.done_cnt = 6'h00;
      next_r.aborted = r.state != S_DONE;
      next_r.state = S_IDLE;
    end
  end

  // system domain register
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= SYS_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs; busy is open drain, driven only when low
  assign LINK.busy_o = 1'b0;
  assign LINK.busy_oe = r.busy_low;
  assign TX_NEXT = r.tx_next;
  assign RX_DATA = r.rx_data;
  assign RX_VALID = r.rx_valid;
  assign SELECTED = r.selected;
  assign LAST_CMD = r.last_cmd;
  assign ABORTED = r.aborted;

endmodule : spi_busy_device

// ### verilog/spi_busy_master.sv
`timescale 1ns/1ps
module spi_busy_master
  import spi_busy_pkg::*;
#(
  parameter int SLOT_CYCLES_P = SLOT_CYCLES
)
(
  // system clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // link to the slave
  spi_busy_link_if.master LINK,
  // slot request
  input wire logic START,
  input wire logic [7:0] CMD,
  output logic READY,
  // data to the slave
  input wire logic [7:0] TX_DATA,
  output logic TX_NEXT,
  // data from the slave
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  // slot end
  output logic DONE,
  output logic TIMEOUT
);

  typedef struct packed {
    mst_state_t state;
    logic busy_meta;
    logic busy_sync;
    logic miso_meta;
    logic miso_sync;
    logic [15:0] slot_cnt;
    logic [9:0] wait_cnt;
    logic [5:0] half_cnt;
    logic [2:0] bit_cnt;
    logic in_cmd;
    logic [7:0] cmd;
    logic [5:0] chars;
    logic [7:0] shift;
    logic sck;
    logic cs_n;
    logic mosi;
    logic ready;
    logic tx_next;
    logic [7:0] rx_data;
    logic rx_valid;
    logic done;
    logic timeout;
  } mst_t;

  localparam mst_t MST_RESET = '{
    state: M_IDLE,
    busy_meta: 1'b1,
    busy_sync: 1'b1,
    sck: 1'b1,
    cs_n: 1'b1,
    default: '0
  };
  localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES_P - 1);

  mst_t r;
  mst_t next_r;
  logic [7:0] shifted;
  logic reads;

  assign shifted = {r.shift[6:0], r.miso_sync};
  assign reads = slave_sends(r.cmd[7:6]) || r.cmd == CMD_STATUS;

  // ==========================================================
  // slot sequencer and bit engine
  always_comb begin
    next_r = r;
    next_r.busy_meta = LINK.busy_n;
    next_r.busy_sync = r.busy_meta;
    next_r.miso_meta = LINK.miso;
    next_r.miso_sync = r.miso_meta;
    next_r.tx_next = 1'b0;
    next_r.rx_valid = 1'b0;
    next_r.done = 1'b0;
    next_r.timeout = 1'b0;
    next_r.wait_cnt = r.wait_cnt + 10'h001;
    if (r.slot_cnt != 16'h0000) begin
      next_r.slot_cnt = r.slot_cnt - 16'h0001;
    end
    next_r.ready = r.state == M_IDLE && next_r.slot_cnt == 16'h0000;
    case (r.state)
      M_IDLE: begin
        if (START && r.ready) begin
          next_r.slot_cnt = SLOT_LAST;
          next_r.ready = 1'b0;
          next_r.cs_n = 1'b0;
          next_r.cmd = CMD;
          next_r.shift = CMD;
          next_r.chars = (CMD == CMD_STATUS) ? STATUS_REPLY_CHARS
                                             : CMD[5:0];
          next_r.in_cmd = 1'b1;
          next_r.wait_cnt = 10'h000;
          next_r.state = M_SEL;
        end
      end
      M_SEL, M_WAIT_LO: begin
        // clock only once the slave shows ready
        if (!r.busy_sync) begin
          if (r.state == M_WAIT_LO && slave_takes(r.cmd[7:6])) begin
            next_r.shift = TX_DATA;
            next_r.tx_next = 1'b1;
          end else if (r.state == M_WAIT_LO) begin
            next_r.shift = IDLE_FILL;
          end
          next_r.half_cnt = 6'h00;
          next_r.bit_cnt = 3'h0;
          next_r.state = M_BYTE;
        end
      end
      M_WAIT_HI: begin
        if (r.busy_sync) begin
          next_r.wait_cnt = 10'h000;
          next_r.state = M_WAIT_LO;
        end
      end
      M_BYTE: begin
        next_r.half_cnt = r.half_cnt + 6'h01;
        if (r.half_cnt == HALF_LAST) begin
          next_r.half_cnt = 6'h00;
          if (r.sck) begin
            next_r.sck = 1'b0;
            next_r.mosi = r.shift[7];
          end else begin
            next_r.sck = 1'b1;
            next_r.shift = shifted;
            next_r.bit_cnt = r.bit_cnt + 3'h1;
            if (r.bit_cnt == 3'h7) begin
              next_r.wait_cnt = 10'h000;
              if (r.in_cmd) begin
                next_r.in_cmd = 1'b0;
                next_r.state = (r.chars == 6'h00) ? M_END : M_WAIT_HI;
              end else begin
                if (reads) begin
                  next_r.rx_data = shifted;
                  next_r.rx_valid = 1'b1;
                end
                next_r.chars = r.chars - 6'h01;
                if (r.chars == 6'h01) begin
                  next_r.state = M_END;
                end else if (slave_takes(r.cmd[7:6])) begin
                  next_r.shift = TX_DATA;
                  next_r.tx_next = 1'b1;
                end else begin
                  next_r.shift = IDLE_FILL;
                end
              end
            end
          end
        end
      end
      M_END: begin
        // hold select half a bit past the last edge
        next_r.half_cnt = r.half_cnt + 6'h01;
        if (r.half_cnt == HALF_LAST) begin
          next_r.cs_n = 1'b1;
          next_r.done = 1'b1;
          next_r.state = M_IDLE;
        end
      end
      default: begin
        next_r.state = M_IDLE;
      end
    endcase
    // a missing handshake never stalls the slot
    if ((r.state == M_SEL || r.state == M_WAIT_HI ||
         r.state == M_WAIT_LO) && r.wait_cnt == TIMEOUT_LAST) begin
      next_r.cs_n = 1'b1;
      next_r.timeout = 1'b1;
      next_r.state = M_IDLE;
    end
  end

  // master register
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= MST_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  assign LINK.sck = r.sck;
  assign LINK.cs_n = r.cs_n;
  assign LINK.mosi = r.mosi;
  assign READY = r.ready;
  assign TX_NEXT = r.tx_next;
  assign RX_DATA = r.rx_data;
  assign RX_VALID = r.rx_valid;
  assign DONE = r.done;
  assign TIMEOUT = r.timeout;

endmodule : spi_busy_master

// ### bench/spi_busy_chk.sv
`timescale 1ns/1ps
module spi_busy_chk (
  // system clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // master driven lines
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  // slave driven and resolved lines
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic busy_o,
  input wire logic busy_oe,
  input wire logic miso,
  input wire logic busy_n
);
  // ==================================================
  // bit and byte tracking on the link
  logic sck_q;
  logic [2:0] bits;
  logic [6:0] bytes;
  logic [6:0] sh;
  logic [7:0] cmd;
  logic [7:0] cmd_now;
  logic [6:0] n_slot;
  logic rise, last, first_done, cmd_ok, last_data;

  // sck rise is seen at the first clock edge after it
  assign rise = sck && !sck_q;
  assign cmd_now = {sh, mosi};
  assign last = rise && (bits == 3'h7);
  assign first_done = last && (bytes == 7'h00);
  assign cmd_ok = (cmd_now == 8'h00) ||
    ((cmd_now[7:6] != 2'h0) && (cmd_now[5:0] != 6'h00));
  assign n_slot = (cmd == 8'h00) ? 7'h01 : {1'b0, cmd[5:0]};
  assign last_data = last && (bytes != 7'h00) && (bytes == n_slot);

  // counters restart on every deselect
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sck_q <= 1'b1;
      bits <= 3'h0;
      bytes <= 7'h00;
      sh <= 7'h00;
      cmd <= 8'h00;
    end else begin
      sck_q <= sck;
      if (cs_n) begin
        bits <= 3'h0;
        bytes <= 7'h00;
      end else if (rise) begin
        sh <= {sh[5:0], mosi};
        bits <= bits + 3'h1;
        if (bits == 3'h7) bytes <= bytes + 7'h01;
        if (first_done) cmd <= cmd_now;
      end
    end
  end

  // ==================================================
  // link properties
  default clocking dflt @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  property p_sck_idle; cs_n [*3] |-> sck; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck not idle");
  property p_miso_free; cs_n [*4] |-> !miso_oe; endproperty
  a_miso_free: assert property (p_miso_free) else $error("miso held");
  property p_busy_free; cs_n [*4] |-> busy_n; endproperty
  a_busy_free: assert property (p_busy_free) else $error("busy low idle");
  property p_sel_ready; $fell(cs_n) |-> busy_n [*2] ##[1:6] !busy_n; endproperty
  a_sel_ready: assert property (p_sel_ready) else $error("no ready");
  property p_clk_gate; $fell(sck) && (bits == 3'h0) |-> !$past(busy_n); endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("early sck");
  property p_cmd_busy; first_done |-> ##[1:8] busy_n; endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("busy not high");
  property p_exec; first_done && cmd_ok |-> ##[1:8] busy_n ##[1:8] !busy_n; endproperty
  a_exec: assert property (p_exec) else $error("busy not low again");
  property p_refuse; first_done && !cmd_ok |-> ##8 busy_n [*8]; endproperty
  a_refuse: assert property (p_refuse) else $error("bad command run");
  property p_end_busy; last_data |-> ##[1:8] busy_n; endproperty
  a_end_busy: assert property (p_end_busy) else $error("busy low at end");
  property p_mosi_hold; !cs_n && !$past(cs_n) && sck && $past(sck) |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved");
  property p_miso_hold; miso_oe && $past(miso_oe) && sck && $past(sck) |-> $stable(miso_o); endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved");
endmodule : spi_busy_chk

// ### bench/tb.sv
`timescale 1ns/1ps
module tb;
  import spi_busy_pkg::*;
  // short slot spacing keeps the run small
  localparam int SP = 2000;
  // ==================================================
  // stimulus and observed pins
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] m_txd = 8'h00;
  logic [7:0] d_txd = 8'h00;
  logic [5:0] tx_count = 6'h00;
  logic [5:0] rx_room = 6'h00;
  logic m_ready, m_txn, m_rxv, m_done, m_to;
  logic d_txn, d_rxv, d_sel, d_abort;
  logic [7:0] m_rxd, d_rxd, d_last, wm, ws;
  logic [7:0] mbuf [128];
  logic [7:0] dbuf [128];
  logic [7:0] mrx [$];
  logic [7:0] drx [$];
  logic [7:0] wmq [$];
  logic [7:0] wsq [$];
  logic [7:0] plan [8] = '{8'h00, 8'h00, 8'h41, 8'h88, 8'hFF, 8'h05,
    8'h80, 8'hC1};
  int mi, di, wb, ndone, nto, nab;
  int since = SP;
  int failures = 0;
  int n_compared = 0;

  // 25 ns period
  always #12.5 clock = ~clock;

  // ==================================================
  // both ends and the checker
  spi_busy_link_if link ();
  spi_busy_master #(.SLOT_CYCLES_P(SP)) u_spi_busy_master (
    .CLOCK(clock), .RESET_N(reset_n), .LINK(link), .START(start),
    .CMD(cmd), .READY(m_ready), .TX_DATA(m_txd), .TX_NEXT(m_txn),
    .RX_DATA(m_rxd), .RX_VALID(m_rxv), .DONE(m_done), .TIMEOUT(m_to));
  spi_busy_device u_spi_busy_device (
    .CLOCK(clock), .RESET_N(reset_n), .LINK(link),
    .TX_COUNT(tx_count), .TX_DATA(d_txd), .TX_NEXT(d_txn),
    .RX_ROOM(rx_room), .RX_DATA(d_rxd), .RX_VALID(d_rxv),
    .SELECTED(d_sel), .LAST_CMD(d_last), .ABORTED(d_abort));
  spi_busy_chk u_spi_busy_chk (
    .CLOCK(clock), .RESET_N(reset_n), .sck(link.sck),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso_o(link.miso_o),
    .miso_oe(link.miso_oe), .busy_o(link.busy_o),
    .busy_oe(link.busy_oe), .miso(link.miso), .busy_n(link.busy_n));

  // ==================================================
  // user side monitors; one-cycle pulses are seen once here
  always @(negedge clock) begin
    if (m_rxv) mrx.push_back(m_rxd);
    if (d_rxv) drx.push_back(d_rxd);
    if (m_txn) mi++;
    if (d_txn) di++;
    if (m_done) ndone++;
    if (m_to) nto++;
    if (d_abort) nab++;
    since++;
    m_txd = mbuf[mi];
    d_txd = dbuf[di];
  end

  // wire bytes as they cross, msb first
  always @(posedge link.sck) begin
    if (!link.cs_n) begin
      wm = {wm[6:0], link.mosi};
      ws = {ws[6:0], link.miso};
      wb++;
      if (wb % 8 == 0) begin
        wmq.push_back(wm);
        wsq.push_back(ws);
      end
    end
  end

  // ==================================================
  // checking and closing
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // a wait that ran out ends the run
  task automatic hang_check(input logic ok);
    if (!ok) begin
      chk("wait", 1, 0);
      give_verdict();
    end
  endtask : hang_check

  // one slot end to end, compared with the byte model
  task automatic run_slot(input logic [7:0] c, input logic [5:0] tc);
    logic [1:0] op;
    logic ok;
    int n;
    int exp_m;
    op = c[7:6];
    n = (c == 8'h00) ? 1 : int'(c[5:0]);
    // only a nonzero count under op 00 is refused; zero count ends
    ok = (op != 2'h0) || (c[5:0] == 6'h00);
    exp_m = !ok ? 0 : ((c == 8'h00 || op[0]) ? n : 0);
    foreach (mbuf[k]) begin
      mbuf[k] = 8'($urandom);
      dbuf[k] = 8'($urandom);
    end
    for (int k = 0; k < 3000 && m_ready !== 1'b1; k++)
      @(negedge clock);
    hang_check(m_ready === 1'b1);
    chk("slot spacing", 1, since >= SP - 1);
    {mi, di, wb, ndone, nto, nab} = '0;
    mrx.delete();
    drx.delete();
    wmq.delete();
    wsq.delete();
    tx_count = tc;
    rx_room = 6'($urandom);
    cmd = c;
    start = 1'b1;
    since = 0;
    @(negedge clock);
    // start held a second cycle: that request must be dropped
    chk("ready after start", 0, m_ready);
    @(negedge clock);
    start = 1'b0;
    // select crosses two flops and a register before showing
    repeat (3) @(negedge clock);
    chk("selected during slot", 1, d_sel);
    for (int k = 0; k < 30000 && ndone + nto == 0; k++)
      @(negedge clock);
    hang_check(ndone + nto != 0);
    repeat (8) @(negedge clock);
    chk("done", ok, ndone);
    chk("timeout", !ok, nto);
    // a refused slot still reaches its end state, so no abort
    chk("aborted", 0, nab);
    chk("selected", 0, d_sel);
    chk("last command", c, d_last);
    chk("command on wire", c, wmq[0]);
    if (c == 8'h00) begin
      chk("status", (tc != 0) ? {2'h1, tc} : {2'h0, rx_room}, mrx[0]);
      chk("status wire", (tc != 0) ? {2'h1, tc} : {2'h0, rx_room}, wsq[1]);
    end
    for (int k = 0; k < n && ok && c != 8'h00; k++) begin
      if (op[0]) chk("master rx byte", dbuf[k], mrx[k]);
      if (op[0]) chk("miso byte", dbuf[k], wsq[k + 1]);
      if (op[1]) chk("slave rx byte", mbuf[k], drx[k]);
      if (op[1]) chk("mosi byte", mbuf[k], wmq[k + 1]);
    end
    chk("master rx count", exp_m, mrx.size());
    chk("slave rx count", (ok && op[1]) ? n : 0, drx.size());
  endtask : run_slot

  // ==================================================
  // main sequence
  initial begin
    void'($urandom(43424));
    repeat (4) @(negedge clock);
    reset_n = 1'b1;
    foreach (plan[i])
      run_slot(plan[i], (i == 1) ? 6'h00 : 6'($urandom_range(1, 63)));
    repeat (3)
      run_slot({2'($urandom_range(1, 3)), 6'($urandom_range(1, 12))}, 6'h05);
    give_verdict();
  end
endmodule : tb
